//--- hdl/spi_pkg.sv
// constants for the serial port status and data buffer block
package spi_pkg;
  // ***********************************************
  // register map
  // ***********************************************
  localparam int         ADDR_W        = 8;
  localparam int         IDX_CTRL1     = 0;
  localparam int         IDX_CTRL2     = 1;
  localparam int         IDX_STATUS    = 3;
  localparam int         IDX_DATA_HI   = 4;
  localparam int         IDX_DATA_LO   = 5;
  localparam int         IDX_DATA_WORD = 6;
  localparam int         IDX_IRQ_STAT  = 8;
  localparam int         IDX_IRQ_MASK  = 9;
  localparam logic [7:0] ADDR_CTRL1     = 8'(IDX_CTRL1 * 4);
  localparam logic [7:0] ADDR_CTRL2     = 8'(IDX_CTRL2 * 4);
  localparam logic [7:0] ADDR_STATUS    = 8'(IDX_STATUS * 4);
  localparam logic [7:0] ADDR_DATA_HI   = 8'(IDX_DATA_HI * 4);
  localparam logic [7:0] ADDR_DATA_LO   = 8'(IDX_DATA_LO * 4);
  localparam logic [7:0] ADDR_DATA_WORD = 8'(IDX_DATA_WORD * 4);
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'(IDX_IRQ_STAT * 4);
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'(IDX_IRQ_MASK * 4);
  // ***********************************************
  // fields and reset values
  // ***********************************************
  localparam int          ST_RCF_BIT   = 7;
  localparam int          ST_TEF_BIT   = 5;
  localparam int          ST_MFF_BIT   = 4;
  localparam int          C1_MASTER    = 0;
  localparam int          C1_PIE       = 1;
  localparam int          C2_MFDE      = 0;
  localparam int          C2_WIDTH     = 1;
  localparam int          IRQ_RX       = 0;
  localparam int          IRQ_TX       = 1;
  localparam int          IRQ_MF       = 2;
  localparam int          IRQ_N        = 3;
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam logic [15:0] DATA_RST     = 16'h0000;
  localparam logic [2:0]  IRQ_RST      = 3'h0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [4:0]  BITS_BYTE    = 5'h08;
  localparam logic [4:0]  BITS_WORD    = 5'h10;
  // ***********************************************
  // link timing
  // ***********************************************
  localparam int CLK_KHZ      = 10000;
  localparam int SCK_HALF_NS  = 400;
  localparam int HALF_CYC     = (SCK_HALF_NS * CLK_KHZ) / 1000000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } eng_state_t;
endpackage

//--- hdl/spi_status_buffer.sv
// serial port status flags, data buffer, shift engine and bus slave
`timescale 1ns/1ns
module spi_status_buffer
  import spi_pkg::*;
#(
  parameter int HALF_CYC_P = HALF_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [7:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  output logic             irq_out,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n_out,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_n_out,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_n_out,
  input  wire logic        ss_n_in
);
  // ***********************************************
  // declarations
  // ***********************************************
  logic             awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]       bresp_r, rresp_r;
  logic [7:0]       aw_addr_r;
  logic [31:0]      w_data_r, rdata_r, rdata_nxt;
  logic [3:0]       w_strb_r;
  logic             wr_fire, rd_fire, rd_ok;
  logic [1:0]       ctrl1_r, ctrl2_r;
  logic             rcf_r, tef_r, mff_r;
  logic             rx_armed_r, tx_armed_r, mf_armed_r;
  logic [15:0]      data_rx_r, held_r, tx_buf_r, shift_r, rx_word;
  logic             held_v_r, latch_r, sck_r;
  logic [7:0]       div_cnt_r;
  logic [4:0]       bit_cnt_r, nbits;
  eng_state_t       state_r;
  logic             sck_s1, sck_s2, sck_s3, ss_s1, ss_s2, ss_s3;
  logic             mosi_s1, mosi_s2, miso_s1, miso_s2;
  logic             master, wide_sel, fault, abort, tick, sh_rise, sh_fall;
  logic             last, xfer_start, xfer_done, out_bit, rx_clr;
  logic             rd_status, lo_read, hi_write, lo_write, wr_ctrl1;
  logic [IRQ_N-1:0] irq_stat_r, irq_mask_r, flags_d_r, flags;
  logic             irq_r, sck_o_r, sck_oe_r, mosi_o_r, mosi_oe_r;
  logic             miso_o_r, miso_oe_r;

  // ***********************************************
  // bus slave
  // ***********************************************
  assign wr_fire = !awready_r && !wready_r && !bvalid_r;
  assign rd_fire = arvalid_in && arready_r;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (awvalid_in && awready_r) begin
        awready_r <= 1'b0;
        aw_addr_r <= awaddr_in;
      end
      if (wvalid_in && wready_r) begin
        wready_r <= 1'b0;
        w_data_r <= wdata_in;
        w_strb_r <= wstrb_in;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        case (aw_addr_r)
          ADDR_CTRL1, ADDR_CTRL2, ADDR_STATUS, ADDR_DATA_HI,
          ADDR_DATA_LO, ADDR_DATA_WORD, ADDR_IRQ_STAT,
          ADDR_IRQ_MASK: bresp_r <= RESP_OKAY;
          default:       bresp_r <= RESP_SLVERR;
        endcase
      end
      if (bvalid_r && bready_in) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rd_ok     = 1'b1;
    case (araddr_in)
      ADDR_CTRL1:     rdata_nxt = {30'h0, ctrl1_r};
      ADDR_CTRL2:     rdata_nxt = {30'h0, ctrl2_r};
      ADDR_STATUS:    rdata_nxt = {24'h0, rcf_r, 1'b0, tef_r, mff_r,
                                   4'h0};
      ADDR_DATA_HI:   rdata_nxt = {24'h0, data_rx_r[15:8]};
      ADDR_DATA_LO:   rdata_nxt = {24'h0, data_rx_r[7:0]};
      ADDR_DATA_WORD: rdata_nxt = {16'h0, data_rx_r};
      ADDR_IRQ_STAT:  rdata_nxt = {29'h0, irq_stat_r};
      ADDR_IRQ_MASK:  rdata_nxt = {29'h0, irq_mask_r};
      default:        rd_ok     = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else if (rd_fire) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready_in) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // access decode; status writes fall through unused
  assign rd_status = rd_fire && araddr_in == ADDR_STATUS;
  assign lo_read   = rd_fire && (araddr_in == ADDR_DATA_LO ||
                                 araddr_in == ADDR_DATA_WORD);
  assign hi_write  = wr_fire && w_strb_r[1] && aw_addr_r == ADDR_DATA_WORD
                     || wr_fire && w_strb_r[0] && aw_addr_r == ADDR_DATA_HI;
  assign lo_write  = wr_fire && w_strb_r[0] &&
                     (aw_addr_r == ADDR_DATA_LO ||
                      aw_addr_r == ADDR_DATA_WORD);
  assign wr_ctrl1  = wr_fire && w_strb_r[0] && aw_addr_r == ADDR_CTRL1;

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {sck_s1, sck_s2, sck_s3}  <= 3'h0;
      {ss_s1, ss_s2, ss_s3}     <= 3'h7;
      {mosi_s1, mosi_s2}        <= 2'h0;
      {miso_s1, miso_s2}        <= 2'h0;
    end else begin
      {sck_s1, sck_s2, sck_s3}  <= {sck_in, sck_s1, sck_s2};
      {ss_s1, ss_s2, ss_s3}     <= {ss_n_in, ss_s1, ss_s2};
      {mosi_s1, mosi_s2}        <= {mosi_in, mosi_s1};
      {miso_s1, miso_s2}        <= {miso_in, miso_s1};
    end
  end

  // ***********************************************
  // shift engine
  // ***********************************************
  assign master  = ctrl1_r[C1_MASTER];
  assign wide_sel = ctrl2_r[C2_WIDTH];
  assign nbits   = wide_sel ? BITS_WORD : BITS_BYTE;
  assign fault   = master && ctrl2_r[C2_MFDE] && ss_s3 && !ss_s2;
  assign abort   = master ? fault : ss_s2;
  assign tick    = div_cnt_r == 8'h00;
  assign sh_rise = master ? (tick && !sck_r) : (sck_s2 && !sck_s3);
  assign sh_fall = master ? (tick && sck_r) : (!sck_s2 && sck_s3);
  assign last    = bit_cnt_r == nbits - 5'h01;
  assign out_bit = wide_sel ? shift_r[15] : shift_r[7];
  assign xfer_start = state_r == ST_IDLE &&
                      (master ? (!tef_r && !fault) : !ss_s2);
  assign xfer_done  = state_r == ST_RUN && !abort && sh_fall && last;
  assign rx_word    = wide_sel ? {shift_r[14:0], latch_r}
                               : {8'h00, shift_r[6:0], latch_r};

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 5'h00;
      shift_r   <= DATA_RST;
      latch_r   <= 1'b0;
      sck_r     <= 1'b0;
      div_cnt_r <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          sck_r     <= 1'b0;
          div_cnt_r <= 8'(HALF_CYC_P - 1);
          if (xfer_start) begin
            state_r   <= ST_RUN;
            bit_cnt_r <= 5'h00;
            shift_r   <= tef_r ? DATA_RST : tx_buf_r;
          end
        end
        ST_RUN: begin
          if (abort) begin
            state_r <= ST_IDLE;
          end else begin
            if (master && tick) begin
              div_cnt_r <= 8'(HALF_CYC_P - 1);
              sck_r     <= !sck_r;
            end else if (master) begin
              div_cnt_r <= div_cnt_r - 8'h01;
            end
            if (sh_rise) begin
              latch_r <= master ? miso_s2 : mosi_s2;
            end
            if (sh_fall) begin
              shift_r   <= {shift_r[14:0], latch_r};
              bit_cnt_r <= bit_cnt_r + 5'h01;
              if (last) begin
                state_r <= ST_IDLE;
              end
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ***********************************************
  // receive buffer
  // ***********************************************
  assign rx_clr = lo_read && rx_armed_r;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rcf_r      <= 1'b0;
      rx_armed_r <= 1'b0;
      data_rx_r  <= DATA_RST;
      held_r     <= DATA_RST;
      held_v_r   <= 1'b0;
    end else begin
      if (rd_status) begin
        rx_armed_r <= rcf_r;
      end else if (lo_read) begin
        rx_armed_r <= 1'b0;
      end
      if (rx_clr) begin
        if (held_v_r) begin
          data_rx_r <= held_r;
          held_v_r  <= xfer_done;
          if (xfer_done) begin
            held_r <= rx_word;
          end
        end else if (xfer_done) begin
          data_rx_r <= rx_word;
        end else begin
          rcf_r <= 1'b0;
        end
      end else if (xfer_done) begin
        if (!rcf_r) begin
          data_rx_r <= rx_word;
          rcf_r     <= 1'b1;
        end else begin
          held_r   <= rx_word;
          held_v_r <= 1'b1;
        end
      end else if (xfer_start) begin
        held_v_r <= 1'b0;
      end
    end
  end

  // ***********************************************
  // transmit buffer
  // ***********************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tef_r      <= 1'b1;
      tx_armed_r <= 1'b0;
      tx_buf_r   <= DATA_RST;
    end else begin
      if (rd_status) begin
        tx_armed_r <= tef_r;
      end
      if (tef_r) begin
        if (hi_write) begin
          tx_buf_r[15:8] <= w_data_r[15:8] & {8{aw_addr_r ==
                            ADDR_DATA_WORD}} | w_data_r[7:0] &
                            {8{aw_addr_r == ADDR_DATA_HI}};
        end
        if (lo_write && tx_armed_r) begin
          tx_buf_r[7:0] <= w_data_r[7:0];
          tef_r         <= 1'b0;
          tx_armed_r    <= 1'b0;
        end
      end else if (xfer_start) begin
        // word moved to shift register, slave side too
        tef_r <= 1'b1;
      end
    end
  end

  // ***********************************************
  // control and mode fault
  // ***********************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl1_r    <= CTRL_RST;
      ctrl2_r    <= CTRL_RST;
      mff_r      <= 1'b0;
      mf_armed_r <= 1'b0;
    end else begin
      if (rd_status) begin
        mf_armed_r <= mff_r;
      end
      if (wr_ctrl1) begin
        ctrl1_r <= w_data_r[1:0];
      end
      if (wr_fire && w_strb_r[0] && aw_addr_r == ADDR_CTRL2) begin
        ctrl2_r <= w_data_r[1:0];
      end
      if (fault) begin
        mff_r              <= 1'b1;
        ctrl1_r[C1_MASTER] <= 1'b0;
      end else if (wr_ctrl1 && mf_armed_r) begin
        mff_r      <= 1'b0;
        mf_armed_r <= 1'b0;
      end
    end
  end

  // ***********************************************
  // interrupts
  // ***********************************************
  assign flags = {mff_r, tef_r, rcf_r};

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flags_d_r  <= IRQ_RST;
      // tx empty idles high, so no false rise after reset
      flags_d_r[IRQ_TX] <= 1'b1;
      irq_stat_r <= IRQ_RST;
      irq_mask_r <= IRQ_RST;
      irq_r      <= 1'b0;
    end else begin
      flags_d_r  <= flags;
      if (wr_fire && w_strb_r[0] && aw_addr_r == ADDR_IRQ_STAT) begin
        irq_stat_r <= irq_stat_r & ~w_data_r[IRQ_N-1:0] |
                      flags & ~flags_d_r;
      end else begin
        irq_stat_r <= irq_stat_r | flags & ~flags_d_r;
      end
      if (wr_fire && w_strb_r[0] && aw_addr_r == ADDR_IRQ_MASK) begin
        irq_mask_r <= w_data_r[IRQ_N-1:0];
      end
      irq_r <= ctrl1_r[C1_PIE] && |(irq_stat_r & irq_mask_r);
    end
  end

  // ***********************************************
  // pin drivers
  // ***********************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {sck_o_r, mosi_o_r, miso_o_r}    <= 3'h0;
      {sck_oe_r, mosi_oe_r, miso_oe_r} <= 3'h7;
    end else begin
      sck_o_r   <= sck_r;
      sck_oe_r  <= !master;
      mosi_o_r  <= out_bit;
      mosi_oe_r <= !master;
      miso_o_r  <= out_bit;
      miso_oe_r <= master || ss_s2;
    end
  end

  assign awready_out   = awready_r;
  assign wready_out    = wready_r;
  assign bvalid_out    = bvalid_r;
  assign bresp_out     = bresp_r;
  assign arready_out   = arready_r;
  assign rvalid_out    = rvalid_r;
  assign rdata_out     = rdata_r;
  assign rresp_out     = rresp_r;
  assign irq_out       = irq_r;
  assign sck_out       = sck_o_r;
  assign sck_oe_n_out  = sck_oe_r;
  assign mosi_out      = mosi_o_r;
  assign mosi_oe_n_out = mosi_oe_r;
  assign miso_out      = miso_o_r;
  assign miso_oe_n_out = miso_oe_r;

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_rx_service;
    rx_clr && !held_v_r && !xfer_done;
  endsequence
  sequence s_tx_armed_write;
    lo_write && tef_r && tx_armed_r;
  endsequence

  property p_rx_set;
    xfer_done && !rcf_r && !rx_clr |=> rcf_r && data_rx_r == $past(rx_word);
  endproperty
  a_rx_set: assert property (p_rx_set)
    else $error("receive flag not set on completion");
  property p_rx_clear;
    s_rx_service |=> !rcf_r;
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("receive flag not cleared by service");
  property p_hi_read;
    rd_fire && araddr_in == ADDR_DATA_HI && !xfer_done |=> $stable(rcf_r);
  endproperty
  a_hi_read: assert property (p_hi_read)
    else $error("high byte read changed receive flag");
  property p_tef_read;
    rd_status |=> rdata_out[ST_TEF_BIT] == $past(tef_r);
  endproperty
  a_tef_read: assert property (p_tef_read)
    else $error("status read shows wrong transmit flag");
  property p_tx_load;
    s_tx_armed_write |=> !tef_r ##1 1'b1;
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("armed low write did not fill transmit");
  property p_tx_ignore;
    !tef_r && (hi_write || lo_write) |=> $stable(tx_buf_r);
  endproperty
  a_tx_ignore: assert property (p_tx_ignore)
    else $error("write taken while transmit occupied");
  property p_mf_set;
    fault |=> mff_r && !master;
  endproperty
  a_mf_set: assert property (p_mf_set)
    else $error("mode fault not flagged");
  property p_mf_clr;
    wr_ctrl1 && mf_armed_r && !fault |=> !mff_r;
  endproperty
  a_mf_clr: assert property (p_mf_clr)
    else $error("mode fault not cleared");
  property p_held;
    xfer_done && rcf_r && !rx_clr |=> held_v_r && $stable(data_rx_r);
  endproperty
  a_held: assert property (p_held)
    else $error("second word not held");
  property p_irq;
    fault && !mff_r && ctrl1_r[C1_PIE] && irq_mask_r[IRQ_MF] &&
      !wr_fire ##1 !wr_fire |=> ##1 irq_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("mode fault interrupt missing");
endmodule

//--- verif/spi_far_model.sv
// far-side mode 0 slave model clocked by the port's serial clock
`timescale 1ns/1ns
module spi_far_model (
  input  wire logic        sck_in,
  input  wire logic        mosi_in,
  input  wire logic        wide_in,
  input  wire logic        load_in,
  input  wire logic [15:0] tx_in,
  output logic             miso_out,
  output logic [15:0]      rx_out
);
  logic [15:0] sh_r;
  logic [4:0]  cnt_r;
  logic        end_r;
  logic        cur;
  // sample on rising edge, msb first
  always @(posedge sck_in or posedge load_in) begin
    if (load_in) begin
      rx_out <= 16'h0000;
      cnt_r  <= 5'h00;
    end else begin
      rx_out <= {rx_out[14:0], mosi_in};
      cnt_r  <= cnt_r + 5'h01;
    end
  end
  // shift on falling edge, frame ends after last bit
  always @(negedge sck_in or posedge load_in) begin
    if (load_in) begin
      sh_r  <= tx_in;
      end_r <= 1'b0;
    end else begin
      sh_r  <= {sh_r[14:0], 1'b0};
      end_r <= (cnt_r == (wide_in ? 5'h10 : 5'h08));
    end
  end
  // after the last bit the line shows the inverse of the emptied shift bit, so it sits high
  assign cur      = wide_in ? sh_r[15] : sh_r[7];
  assign miso_out = end_r ? ~cur : cur;
endmodule

//--- verif/tb_spi_status_and_data_buffer.sv
// self-checking bench for the serial port status and data buffer
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  fail_count++; $display("Error %0t got %h exp %h", $time, a, b); end end
module tb_spi_status_and_data_buffer;
  import spi_pkg::*;
  logic        clk = 0, nrst = 0;
  logic [7:0]  aw_a = 0, ar_a = 0;
  logic [31:0] w_d = 0, r_d;
  logic [3:0]  w_s = 0;
  logic        aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
  logic [1:0]  b_resp, r_resp;
  logic        sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic        m_miso, m_wide = 0, m_load = 0, ss_n = 1;
  logic [15:0] m_tx = 0, m_rx, t;
  logic [33:0] exp_q[$], e;
  int          fail_count = 0, cmp_count = 0;
  wire sck_w  = sck_oe_n ? 1'b0 : sck_o;
  wire mosi_w = mosi_oe_n ? 1'b0 : mosi_o;
  wire miso_w = miso_oe_n ? m_miso : miso_o;
  spi_status_buffer dut (
    .ref_clk_in(clk), .nrst_in(nrst), .awaddr_in(aw_a),
    .awvalid_in(aw_v), .awready_out(aw_rdy), .wdata_in(w_d),
    .wstrb_in(w_s), .wvalid_in(w_v), .wready_out(w_rdy),
    .bresp_out(b_resp), .bvalid_out(b_v), .bready_in(b_r),
    .araddr_in(ar_a), .arvalid_in(ar_v), .arready_out(ar_rdy),
    .rdata_out(r_d), .rresp_out(r_resp), .rvalid_out(r_v),
    .rready_in(r_r), .irq_out(irq), .sck_in(sck_w), .sck_out(sck_o),
    .sck_oe_n_out(sck_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_o),
    .mosi_oe_n_out(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_o),
    .miso_oe_n_out(miso_oe_n), .ss_n_in(ss_n));
  spi_far_model far (
    .sck_in(sck_w), .mosi_in(mosi_w), .wide_in(m_wide),
    .load_in(m_load), .tx_in(m_tx), .miso_out(m_miso), .rx_out(m_rx));
  // ***********************************
  // bus tasks and checking
  // ***********************************
  function automatic logic [33:0] ok(input logic [31:0] d);
    return {RESP_OKAY, d};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    @(posedge clk);
    exp_q.push_back(ok(32'h0));
    aw_a <= a;
    w_d  <= d;
    w_s  <= 4'hf;
    aw_v <= 1;
    w_v  <= 1;
    b_r  <= 1;
    ad = 0;
    wd = 0;
    do begin
      @(posedge clk);
      if (aw_rdy && !ad) begin
        ad = 1;
        aw_v <= 0;
      end
      if (w_rdy && !wd) begin
        wd = 1;
        w_v <= 0;
      end
    end while (!(ad && wd));
    do @(posedge clk); while (!b_v);
    b_r <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    @(posedge clk);
    exp_q.push_back(x);
    ar_a <= a;
    ar_v <= 1;
    r_r  <= 1;
    do @(posedge clk); while (!ar_rdy);
    ar_v <= 0;
    do @(posedge clk); while (!r_v);
    r_r <= 0;
  endtask
  always @(posedge clk) begin
    if (b_v && b_r) begin
      e = exp_q.pop_front();
      `CHK({b_resp, 32'h0}, e)
    end
    if (r_v && r_r) begin
      e = exp_q.pop_front();
      `CHK({r_resp, r_d}, e)
    end
  end
  task automatic test_done;
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ***********************************
  // clock, watchdog and scenarios
  // ***********************************
  initial forever #50 clk = ~clk;
  initial begin
    #(20000 * 100);
    fail_count++;
    test_done();
  end
  initial begin
    void'($urandom(72148));
    repeat (12) @(posedge clk);
    nrst <= 1;
    rd(ADDR_STATUS, ok(32'h20));
    rd(ADDR_DATA_HI, ok(32'h0));
    rd(ADDR_DATA_LO, ok(32'h0));
    rd(8'h3c, {RESP_SLVERR, 32'h0});
    wr(ADDR_STATUS, 32'hff);
    rd(ADDR_STATUS, ok(32'h20));
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_CTRL1, 32'h3);
    for (int w = 0; w < 2; w++) begin
      wr(ADDR_CTRL2, 32'(w * 2));
      t = 16'($urandom);
      m_tx <= 16'($urandom);
      m_wide <= w[0];
      m_load <= 1;
      @(posedge clk);
      m_load <= 0;
      rd(ADDR_STATUS, ok(32'h20));
      wr(ADDR_DATA_HI, 32'(t[15:8]));
      wr(ADDR_DATA_HI, 32'(t[15:8]));
      rd(ADDR_STATUS, ok(32'h20));
      wr(ADDR_DATA_LO, 32'(t[7:0]));
      // no status read since the load: this write must be ignored
      wr(ADDR_DATA_LO, 32'(~t[7:0]));
      rd(ADDR_STATUS, ok(32'h20));
      while (!irq) @(posedge clk);
      rd(ADDR_IRQ_STAT, ok(32'h3));
      wr(ADDR_IRQ_STAT, 32'h3);
      rd(ADDR_STATUS, ok(32'ha0));
      repeat (2) rd(ADDR_DATA_HI, ok(w ? 32'(m_tx[15:8]) : 0));
      rd(ADDR_DATA_LO, ok(32'(m_tx[7:0])));
      rd(ADDR_STATUS, ok(32'h20));
      `CHK(m_rx, w ? t : {8'h00, t[7:0]})
    end
    wr(ADDR_CTRL2, 32'h1);
    ss_n <= 0;
    repeat (8) @(negedge clk);
    `CHK(irq, 1'b0)
    rd(ADDR_STATUS, ok(32'h30));
    wr(ADDR_IRQ_MASK, 32'h4);
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b1)
    @(posedge clk);
    ss_n <= 1;
    wr(ADDR_CTRL1, 32'h3);
    rd(ADDR_STATUS, ok(32'h20));
    wr(ADDR_IRQ_STAT, 32'h4);
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b0)
    test_done();
  end
endmodule
